//--- shared/adcc_pkg.sv
// Constants and types shared by the converter control block
// What this block does
// - Bus clock gate bit is set after reset; clearing it stops the converter clock.
// - Codes 00000 to 00111 select AD0 to AD7, each with its own pin-control bit.
// - Codes 10000 to 10111 select AD16 to AD23, with no pin-control bit.
// - Reserved codes 11000, 11001, 11100 still convert; the value is unspecified.
// - Code 11010 routes the temperature sensor, code 11011 the bandgap reference.
// - Code 11101 selects high reference, 11110 low reference, 11111 disables.
// - Converter clock comes from bus, bus/2, local async or alternate clock.
// - With hardware trigger selected, each counter match while no conversion is running starts one.
// - The counter-match trigger works even with the counter interrupt off.
// - The counter-match trigger fires in run, wait and stop3.
// - Results are 12-bit SAR values, right-justified as 12, 10 or 8 bits.
// - Single conversion returns to idle; continuous conversion repeats.
// - Optional compare flags results below, or at or above, a programmed value.
// - End of conversion sets a completion flag and, if enabled, an interrupt request.
// - Up to 28 inputs, chosen only by the 5-bit channel select field.
// - Sample time and speed versus power are configurable.
// - Writing control register one aborts, and restarts unless channel is all ones or hardware trigger is selected.
// - All-ones channel switches the SAR off and stops continuous conversion.
// - Completion flag clears on control register one write or low result read.
package adcc_pkg;
   localparam int          ADDR_W         = 6;
   localparam int          RES_BITS       = 12;
   localparam int          NUM_INPUTS     = 28;
   // Register byte offsets
   localparam logic [5:0]  REG_CTRL1      = 6'h00;
   localparam logic [5:0]  REG_CTRL2      = 6'h04;
   localparam logic [5:0]  REG_RES_HI     = 6'h08;
   localparam logic [5:0]  REG_RES_LO     = 6'h0C;
   localparam logic [5:0]  REG_CMP        = 6'h10;
   localparam logic [5:0]  REG_CFG        = 6'h14;
   localparam logic [5:0]  REG_PINCTL     = 6'h18;
   localparam logic [5:0]  REG_CLKGATE    = 6'h1C;
   // Field positions
   localparam int          C1_DONE_BIT    = 7;
   localparam int          C1_IEN_BIT     = 6;
   localparam int          C1_CONT_BIT    = 5;
   localparam int          C2_ACT_BIT     = 7;
   localparam int          C2_HWTRG_BIT   = 6;
   localparam int          C2_CMPEN_BIT   = 5;
   localparam int          C2_CMPGE_BIT   = 4;
   localparam int          CFG_LP_BIT     = 7;
   localparam int          CFG_DIV_LSB    = 5;
   localparam int          CFG_LSMP_BIT   = 4;
   localparam int          CFG_MODE_LSB   = 2;
   localparam int          CFG_SRC_LSB    = 0;
   // Reset values
   localparam logic [4:0]  CHAN_RST       = 5'h1F;
   localparam logic        CLKGATE_RST    = 1'h1;
   localparam logic [7:0]  CFG_RST        = 8'h00;
   // Channel codes
   localparam logic [4:0]  CH_LAST_PIN    = 5'h17;
   localparam logic [4:0]  CH_TEMP        = 5'h1A;
   localparam logic [4:0]  CH_BANDGAP     = 5'h1B;
   localparam logic [4:0]  CH_REFH        = 5'h1D;
   localparam logic [4:0]  CH_REFL        = 5'h1E;
   localparam logic [4:0]  CH_OFF         = 5'h1F;
   // Output formats
   localparam logic [1:0]  MODE_8         = 2'h0;
   localparam logic [1:0]  MODE_12        = 2'h1;
   localparam logic [1:0]  MODE_10        = 2'h2;
   // Converter clock sources
   localparam logic [1:0]  SRC_BUS        = 2'h0;
   localparam logic [1:0]  SRC_BUS_DIV2   = 2'h1;
   localparam logic [1:0]  SRC_LOCAL      = 2'h2;
   localparam logic [1:0]  SRC_ALT        = 2'h3;
   // Timing counts, in converter clock ticks or bus cycles
   localparam logic [4:0]  SAMPLE_SHORT   = 5'h04;
   localparam logic [4:0]  SAMPLE_LONG    = 5'h14;
   localparam logic [2:0]  LOCAL_DIV_LAST = 3'h7;

   typedef enum logic [1:0] {ADCC_IDLE, ADCC_SAMPLE, ADCC_CONVERT} adcc_state_t;
endpackage : adcc_pkg

//--- src/adcc_sar_engine.sv
// Successive-approximation sequencer: sample phase then one bit on the first converter tick after each code settles
module adcc_sar_engine
   import adcc_pkg::*;
#(
   parameter int RBITS = RES_BITS
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             tick,
   input  wire logic             start,
   input  wire logic             abort,
   input  wire logic             sampleLong,
   input  wire logic             cmpIn,
   output logic                  busy,
   output logic                  sampling,
   output logic                  done,
   output logic [RBITS-1:0]      dacCode,
   output logic [RBITS-1:0]      result
);
   adcc_state_t       state_q, state_d;
   logic [4:0]        cnt_q, cnt_d;
   logic [3:0]        bit_q, bit_d;
   logic [RBITS-1:0]  code_q, code_d, res_q, res_d;
   logic              done_q, done_d;
   logic [RBITS-1:0]  kept;
   logic [1:0]        settle_q, settle_d;
   logic              samp_q, samp_d;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      bit_d   = bit_q;
      code_d  = code_q;
      res_d   = res_q;
      done_d  = 1'b0;
      kept    = cmpIn ? code_q : (code_q & ~(RBITS'(1) << bit_q));
      // A restart overrides an abort in the same cycle
      if (start) begin
         state_d = ADCC_SAMPLE;
         cnt_d   = (sampleLong ? SAMPLE_LONG : SAMPLE_SHORT) - 5'h01;
         code_d  = '0;
      end else if (abort) begin
         state_d = ADCC_IDLE;
      end else begin
         case (state_q)
            ADCC_SAMPLE: begin
               if (tick) begin
                  if (cnt_q == 5'h00) begin
                     state_d = ADCC_CONVERT;
                     bit_d   = 4'(RBITS - 1);
                     code_d  = RBITS'(1) << (RBITS - 1);
                  end else begin
                     cnt_d = cnt_q - 5'h01;
                  end
               end
            end
            ADCC_CONVERT: begin
               if (tick && settle_q[1]) begin
                  if (bit_q == 4'h0) begin
                     state_d = ADCC_IDLE;
                     res_d   = kept;
                     code_d  = kept;
                     done_d  = 1'b1;
                  end else begin
                     bit_d  = bit_q - 4'h1;
                     code_d = kept | (RBITS'(1) << (bit_q - 4'h1));
                  end
               end
            end
            default: state_d = ADCC_IDLE;
         endcase
      end
      // Comparator reaches cmpIn through two sync flops: judge a bit only once it has seen this code
      settle_d = (code_d != code_q) ? 2'h0 : ((settle_q == 2'h3) ? 2'h3 : settle_q + 2'h1);
      samp_d   = (state_d == ADCC_SAMPLE);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ADCC_IDLE;
         cnt_q   <= 5'h00;
         bit_q   <= 4'h0;
         code_q  <= '0;
         res_q   <= '0;
         done_q  <= 1'b0;
         settle_q <= 2'h0;
         samp_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         bit_q   <= bit_d;
         code_q  <= code_d;
         res_q   <= res_d;
         done_q  <= done_d;
         settle_q <= settle_d;
         samp_q  <= samp_d;
      end
   end

   assign busy     = (state_q != ADCC_IDLE);
   assign sampling = samp_q;
   assign done     = done_q;
   assign dacCode  = code_q;
   assign result   = res_q;
endmodule : adcc_sar_engine

//--- src/adcc_top.sv
// Converter control: register slave, clock select, channel routing, triggers, flag and compare
//
// Added by the designer: register access over Avalon-MM and the address map.
module adcc_top
   import adcc_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic [ADDR_W-1:0]  avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   input  wire logic               cmpAsyncIn,
   input  wire logic               altClkIn,
   input  wire logic [15:0]        rtcCountValue,
   input  wire logic [15:0]        rtcMatchValue,
   output logic [NUM_INPUTS-1:0]   chanSel,
   output logic                    refHighSel,
   output logic                    refLowSel,
   output logic                    sarPowerOn,
   output logic [7:0]              pinDigitalOff,
   output logic [RES_BITS-1:0]     dacCode,
   output logic                    sampleHold,
   output logic                    lowPowerMode,
   output logic                    busClkEn,
   output logic                    convIrq
);
   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic [4:0]           chanCode_q, chanCode_d;
   logic                 ien_q, ien_d, cont_q, cont_d, doneFlag_q, doneFlag_d;
   logic                 hwTrig_q, hwTrig_d, cmpEn_q, cmpEn_d, cmpGe_q, cmpGe_d;
   logic [RES_BITS-1:0]  cmpVal_q, cmpVal_d, result_q, result_d;
   logic [7:0]           cfg_q, cfg_d, pinCtrl_q, pinCtrl_d;
   logic                 clkGate_q, clkGate_d, waitReq_q, waitReq_d, irq_q, irq_d;
   logic [31:0]          rdata_q, rdata_d;
   logic                 req, acc, ctrl1Wr, resLoRd, setDone, cmpTrue;
   logic [4:0]           wrChan;
   logic [RES_BITS-1:0]  fmtRes;
   logic                 half_q, half_d, altS1_q, altS2_q, altPrev_q, cmpS1_q, cmpS2_q;
   logic [2:0]           locCnt_q, locCnt_d, preCnt_q, preCnt_d;
   logic                 matchPrev_q, matchNow, matchEvt, srcTick, convTick, engStart;
   logic [2:0]           preMask;
   logic [NUM_INPUTS-1:0] chanSel_q, chanSel_d;
   logic                 refH_q, refH_d, refL_q, refL_d, sarOn_q, sarOn_d;
   logic                 engBusy, engSampling, engDone;
   logic [RES_BITS-1:0]  engRes;
   logic [1:0]           mode, clkSrc, div;

   assign mode   = cfg_q[CFG_MODE_LSB +: 2];
   assign clkSrc = cfg_q[CFG_SRC_LSB +: 2];
   assign div    = cfg_q[CFG_DIV_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Bus decode: one wait cycle, then a single accept cycle
   assign req     = avs_read | avs_write;
   assign acc     = req & ~waitReq_q;
   assign ctrl1Wr = acc & avs_write & avs_byteenable[0] & (avs_address == REG_CTRL1);
   assign resLoRd = acc & avs_read & (avs_address == REG_RES_LO);
   assign wrChan  = avs_writedata[4:0];

   // Counter match, same clock domain as this block; the counter's own interrupt enable is not consulted
   assign matchNow = (rtcCountValue == rtcMatchValue);
   assign matchEvt = matchNow & ~matchPrev_q;

   assign cmpTrue = cmpGe_q ? (engRes >= cmpVal_q) : (engRes < cmpVal_q);
   assign setDone = engDone & (~cmpEn_q | cmpTrue);

   always_comb begin
      case (mode)
         MODE_10: fmtRes = {2'h0, engRes[RES_BITS-1:2]};
         MODE_8:  fmtRes = {4'h0, engRes[RES_BITS-1:4]};
         default: fmtRes = engRes;
      endcase
   end

   // Starts: software write, counter match, or continuous repeat; all-ones channel blocks all of them
   always_comb begin
      engStart = 1'b0;
      if (clkGate_q) begin
         if (ctrl1Wr) begin
            engStart = (wrChan != CH_OFF) & ~hwTrig_q;
         end else if (chanCode_q != CH_OFF) begin
            engStart = (hwTrig_q & matchEvt & ~engBusy) | (engDone & cont_q);
         end
      end
   end

   always_comb begin
      chanCode_d = chanCode_q;
      ien_d      = ien_q;
      cont_d     = cont_q;
      hwTrig_d   = hwTrig_q;
      cmpEn_d    = cmpEn_q;
      cmpGe_d    = cmpGe_q;
      cmpVal_d   = cmpVal_q;
      cfg_d      = cfg_q;
      pinCtrl_d  = pinCtrl_q;
      clkGate_d  = clkGate_q;
      result_d   = setDone ? fmtRes : result_q;
      waitReq_d  = ~(req & waitReq_q);
      rdata_d    = rdata_q;
      if (acc & avs_write & avs_byteenable[0]) begin
         case (avs_address)
            REG_CTRL1: begin
               chanCode_d = wrChan;
               ien_d      = avs_writedata[C1_IEN_BIT];
               cont_d     = avs_writedata[C1_CONT_BIT];
            end
            REG_CTRL2: begin
               hwTrig_d = avs_writedata[C2_HWTRG_BIT];
               cmpEn_d  = avs_writedata[C2_CMPEN_BIT];
               cmpGe_d  = avs_writedata[C2_CMPGE_BIT];
            end
            REG_CMP:     cmpVal_d[7:0] = avs_writedata[7:0];
            REG_CFG:     cfg_d         = avs_writedata[7:0];
            REG_PINCTL:  pinCtrl_d     = avs_writedata[7:0];
            REG_CLKGATE: clkGate_d     = avs_writedata[0];
            default: ;
         endcase
      end
      if (acc & avs_write & avs_byteenable[1] & (avs_address == REG_CMP)) begin
         cmpVal_d[RES_BITS-1:8] = avs_writedata[RES_BITS-1:8];
      end
      // The flag's set wins over a clear in the same cycle
      if (setDone) begin
         doneFlag_d = 1'b1;
      end else if (ctrl1Wr | resLoRd) begin
         doneFlag_d = 1'b0;
      end else begin
         doneFlag_d = doneFlag_q;
      end
      irq_d = doneFlag_d & ien_d;
      if (req & waitReq_q) begin
         case (avs_address)
            REG_CTRL1:   rdata_d = {24'h0, doneFlag_q, ien_q, cont_q, chanCode_q};
            REG_CTRL2:   rdata_d = {24'h0, engBusy, hwTrig_q, cmpEn_q, cmpGe_q, 4'h0};
            REG_RES_HI:  rdata_d = {28'h0, result_q[RES_BITS-1:8]};
            REG_RES_LO:  rdata_d = {24'h0, result_q[7:0]};
            REG_CMP:     rdata_d = {20'h0, cmpVal_q};
            REG_CFG:     rdata_d = {24'h0, cfg_q};
            REG_PINCTL:  rdata_d = {24'h0, pinCtrl_q};
            REG_CLKGATE: rdata_d = {31'h0, clkGate_q};
            default:     rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         chanCode_q  <= CHAN_RST;
         ien_q       <= 1'b0;
         cont_q      <= 1'b0;
         doneFlag_q  <= 1'b0;
         hwTrig_q    <= 1'b0;
         cmpEn_q     <= 1'b0;
         cmpGe_q     <= 1'b0;
         cmpVal_q    <= '0;
         cfg_q       <= CFG_RST;
         pinCtrl_q   <= 8'h00;
         clkGate_q   <= CLKGATE_RST;
         result_q    <= '0;
         waitReq_q   <= 1'b1;
         rdata_q     <= 32'h0;
         irq_q       <= 1'b0;
         matchPrev_q <= 1'b0;
      end else begin
         chanCode_q  <= chanCode_d;
         ien_q       <= ien_d;
         cont_q      <= cont_d;
         doneFlag_q  <= doneFlag_d;
         hwTrig_q    <= hwTrig_d;
         cmpEn_q     <= cmpEn_d;
         cmpGe_q     <= cmpGe_d;
         cmpVal_q    <= cmpVal_d;
         cfg_q       <= cfg_d;
         pinCtrl_q   <= pinCtrl_d;
         clkGate_q   <= clkGate_d;
         result_q    <= result_d;
         waitReq_q   <= waitReq_d;
         rdata_q     <= rdata_d;
         irq_q       <= irq_d;
         matchPrev_q <= matchNow;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Converter clock: the local and alternate sources become enables, so the engine stays on sys_clk
   always_comb begin
      half_d   = ~half_q;
      locCnt_d = (locCnt_q == LOCAL_DIV_LAST) ? 3'h0 : locCnt_q + 3'h1;
      case (clkSrc)
         SRC_BUS:      srcTick = 1'b1;
         SRC_BUS_DIV2: srcTick = half_q;
         SRC_LOCAL:    srcTick = (locCnt_q == LOCAL_DIV_LAST);
         SRC_ALT:      srcTick = altS2_q & ~altPrev_q;
         default:      srcTick = 1'b0;
      endcase
      preMask  = 3'((4'h1 << div) - 4'h1);
      preCnt_d = (clkGate_q & srcTick) ? preCnt_q + 3'h1 : preCnt_q;
      // Gate clear freezes the sequencer, which is how the bus clock stop reaches the converter
      convTick = clkGate_q & srcTick & ((preCnt_q & preMask) == preMask);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         half_q    <= 1'b0;
         locCnt_q  <= 3'h0;
         preCnt_q  <= 3'h0;
         altS1_q   <= 1'b0;
         altS2_q   <= 1'b0;
         altPrev_q <= 1'b0;
         cmpS1_q   <= 1'b0;
         cmpS2_q   <= 1'b0;
      end else begin
         half_q    <= half_d;
         locCnt_q  <= locCnt_d;
         preCnt_q  <= preCnt_d;
         altS1_q   <= altClkIn;
         altS2_q   <= altS1_q;
         altPrev_q <= altS2_q;
         cmpS1_q   <= cmpAsyncIn;
         cmpS2_q   <= cmpS1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Channel routing; reserved codes convert with nothing routed, so their value is undefined
   always_comb begin
      chanSel_d = '0;
      if (chanCode_q <= CH_LAST_PIN) begin
         chanSel_d[chanCode_q] = 1'b1;
      end
      if ((chanCode_q == CH_TEMP) | (chanCode_q == CH_BANDGAP)) begin
         chanSel_d[chanCode_q] = 1'b1;
      end
      refH_d  = (chanCode_q == CH_REFH);
      refL_d  = (chanCode_q == CH_REFL);
      sarOn_d = (chanCode_q != CH_OFF);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         chanSel_q <= '0;
         refH_q    <= 1'b0;
         refL_q    <= 1'b0;
         sarOn_q   <= 1'b0;
      end else begin
         chanSel_q <= chanSel_d;
         refH_q    <= refH_d;
         refL_q    <= refL_d;
         sarOn_q   <= sarOn_d;
      end
   end

   adcc_sar_engine #(.RBITS(RES_BITS)) u_engine (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .tick       (convTick),
      .start      (engStart),
      .abort      (ctrl1Wr),
      .sampleLong (cfg_q[CFG_LSMP_BIT]),
      .cmpIn      (cmpS2_q),
      .busy       (engBusy),
      .sampling   (engSampling),
      .done       (engDone),
      .dacCode    (dacCode),
      .result     (engRes)
   );

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = waitReq_q;
   assign chanSel         = chanSel_q;
   assign refHighSel      = refH_q;
   assign refLowSel       = refL_q;
   assign sarPowerOn      = sarOn_q;
   assign pinDigitalOff   = pinCtrl_q;
   assign sampleHold      = engSampling;
   assign lowPowerMode    = cfg_q[CFG_LP_BIT];
   assign busClkEn        = clkGate_q;
   assign convIrq         = irq_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   sequence sWrStart;
      ctrl1Wr && (wrChan != CH_OFF) && !hwTrig_q && clkGate_q;
   endsequence
   sequence sSingleEnd;
      engDone && !cont_q && !engStart;
   endsequence

   AST_GATE_RESET: assert property (@(posedge sys_clk) $fell(rst) |-> clkGate_q && busClkEn)
      else $error("gate bit not set after reset");
   AST_GATE_STOP: assert property (@(posedge sys_clk) disable iff (rst) !clkGate_q |=> $stable(dacCode))
      else $error("converter moved while gated");
   AST_LOW_PINS: assert property (@(posedge sys_clk) disable iff (rst) (chanCode_q <= 5'h07)
      |=> chanSel_q == (28'h1 << $past(chanCode_q)))
      else $error("low pin channel misrouted");
   AST_HIGH_PINS: assert property (@(posedge sys_clk) disable iff (rst)
      (chanCode_q >= 5'h10) && (chanCode_q <= 5'h17) |=> chanSel_q == (28'h1 << $past(chanCode_q)))
      else $error("high pin channel misrouted");
   AST_RESERVED: assert property (@(posedge sys_clk) disable iff (rst)
      (chanCode_q == 5'h18) || (chanCode_q == 5'h19) || (chanCode_q == 5'h1C) |=> chanSel_q == '0 && sarOn_q)
      else $error("reserved channel routed or off");
   AST_TEMP: assert property (@(posedge sys_clk) disable iff (rst) chanCode_q == CH_TEMP
      |=> chanSel_q[26] && !chanSel_q[27])
      else $error("temperature sensor not routed");
   AST_OFF: assert property (@(posedge sys_clk) disable iff (rst) chanCode_q == CH_OFF
      |=> !sarOn_q && chanSel_q == '0 && !refH_q && !refL_q)
      else $error("disabled channel still powered");
   AST_BUS_TICK: assert property (@(posedge sys_clk) disable iff (rst)
      clkGate_q && clkSrc == SRC_BUS && div == 2'h0 |-> convTick)
      else $error("bus clock source not ticking");
   AST_HW_TRIG: assert property (@(posedge sys_clk) disable iff (rst)
      hwTrig_q && matchEvt && clkGate_q && !engBusy && !ctrl1Wr && chanCode_q != CH_OFF |=> engBusy)
      else $error("counter match did not start conversion");
   AST_ONE_EVENT: assert property (@(posedge sys_clk) disable iff (rst) matchEvt |=> !matchEvt)
      else $error("counter match held longer than one cycle");
   AST_FORMAT8: assert property (@(posedge sys_clk) disable iff (rst) setDone && mode == MODE_8
      |=> result_q[RES_BITS-1:8] == 4'h0)
      else $error("8-bit result not right-justified");
   AST_SINGLE: assert property (@(posedge sys_clk) disable iff (rst) sSingleEnd |=> !engBusy)
      else $error("single conversion did not return to idle");
   AST_CMP_MISS: assert property (@(posedge sys_clk) disable iff (rst)
      engDone && cmpEn_q && !cmpTrue && !doneFlag_q |=> !doneFlag_q)
      else $error("flag set on failed compare");
   AST_DONE_SET: assert property (@(posedge sys_clk) disable iff (rst) engDone && !cmpEn_q
      |=> doneFlag_q ##1 (convIrq == (doneFlag_q && ien_q)))
      else $error("completion flag or request missing");
   AST_WR_START: assert property (@(posedge sys_clk) disable iff (rst) sWrStart |=> engBusy ##1 engBusy)
      else $error("control write did not start conversion");
   AST_OFF_STOP: assert property (@(posedge sys_clk) disable iff (rst) ctrl1Wr && wrChan == CH_OFF
      |=> !engBusy)
      else $error("conversion ran with channel all ones");
   AST_CLEAR: assert property (@(posedge sys_clk) disable iff (rst) (ctrl1Wr || resLoRd) && !engDone
      |=> !doneFlag_q)
      else $error("completion flag not cleared");
endmodule : adcc_top

//--- tb/adcc_analog_model.sv
// Analog side: input levels, references and the comparator facing the SAR code
module adcc_analog_model
   import adcc_pkg::*;
(
   input  wire logic                      sys_clk,
   input  wire logic [NUM_INPUTS*12-1:0]  levels,
   input  wire logic [NUM_INPUTS-1:0]     chanSel,
   input  wire logic                      refHighSel,
   input  wire logic                      refLowSel,
   input  wire logic [RES_BITS-1:0]       dacCode,
   output logic                           cmpAsyncIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic toggle_q;
   always @(posedge sys_clk) toggle_q <= ~toggle_q;
   initial toggle_q = 1'b0;
   always_comb begin
      // Nothing routed: a moving level, so a stale value cannot pass
      cmpAsyncIn = toggle_q;
      for (int i = 0; i < NUM_INPUTS; i++) begin
         // Bandgap level stands as buffered: no buffer enable is written or modelled before converting it
         if (chanSel[i]) cmpAsyncIn = levels[i*12+:12] >= dacCode;
      end
      if (refHighSel) cmpAsyncIn = 1'b1;
      if (refLowSel) cmpAsyncIn = dacCode == 12'h000;
   end
endmodule : adcc_analog_model

//--- tb/tb_top.sv
// Testbench: bus master, result reference and scenario sequence
module tb_top import adcc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, rst, avs_read, avs_write, cmpAsyncIn, refH, refL, sarOn, clkEn, sHold, lowPwr, irq, wr;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, rd, q, s;
   logic [15:0] rtcCount;
   logic        altSrc;
   logic [27:0] chanSel;
   logic [11:0] dac;
   logic [7:0]  pinOff;
   logic [NUM_INPUTS*12-1:0] levels;
   logic [4:0]  chs [10] = '{5'h00, 5'h07, 5'h10, 5'h17, 5'h1A, 5'h1B, 5'h1D, 5'h1E, 5'h18, 5'h1C};
   int          nErrors, cmpCount, cyc;
   adcc_top u_adcc_top (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(rd),
      .avs_waitrequest(wr), .cmpAsyncIn(cmpAsyncIn), .altClkIn(altSrc), .rtcCountValue(rtcCount),
      .rtcMatchValue(16'h0055), .chanSel(chanSel), .refHighSel(refH), .refLowSel(refL), .sarPowerOn(sarOn),
      .pinDigitalOff(pinOff), .dacCode(dac), .sampleHold(sHold), .lowPowerMode(lowPwr), .busClkEn(clkEn),
      .convIrq(irq));
   adcc_analog_model u_adcc_analog_model (.sys_clk(sys_clk), .levels(levels), .chanSel(chanSel),
      .refHighSel(refH), .refLowSel(refL), .dacCode(dac), .cmpAsyncIn(cmpAsyncIn));
   ////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmpCount, nErrors);
      if (nErrors == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmpCount++;
      if (g !== e) begin
         nErrors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // Request held until the edge that sees waitrequest low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge sys_clk); while (wr !== 1'b0);
      q = rd;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // One idle edge parts release from the next request and lets written state settle
      @(posedge sys_clk);
   endtask : bus
   task automatic waitDone;
      for (int i = 0; i < 80; i++) begin
         bus(1'b0, REG_CTRL1, 32'h0);
         if (q[C1_DONE_BIT] === 1'b1) break;
      end
   endtask : waitDone
   task automatic conv(input logic [4:0] c, input logic [1:0] m, input logic [1:0] src);
      logic [11:0] v;
      v = c == CH_REFH ? 12'hFFF : c == CH_REFL ? 12'h000 : levels[int'(c)*12+:12];
      v = m == MODE_8 ? v >> 4 : m == MODE_10 ? v >> 2 : v;
      bus(1'b1, REG_CFG, {24'h0, m == MODE_10, 3'h0, m, src});
      bus(1'b1, REG_CTRL1, {24'h0, 3'h2, c});
      chk(32'(sHold), 32'h1);
      waitDone();
      chk(32'(q[C1_DONE_BIT]), 32'h1);
      chk(32'(irq), 32'h1);
      chk({4'h0, chanSel}, (c <= CH_LAST_PIN || c == CH_TEMP || c == CH_BANDGAP) ? 32'h1 << c : 32'h0);
      chk(32'(lowPwr), 32'(m == MODE_10));
      bus(1'b0, REG_RES_HI, 32'h0);
      s = q;
      bus(1'b0, REG_RES_LO, 32'h0);
      if (c != 5'h18 && c != 5'h1C) chk({20'h0, s[3:0], q[7:0]}, 32'(v));
      bus(1'b0, REG_CTRL1, 32'h0);
      chk(32'(q[C1_DONE_BIT]), 32'h0);
   endtask : conv
   ////////////////////////////////////////
   initial begin sys_clk = 1'b0; forever #20 sys_clk = ~sys_clk; end
   always @(posedge sys_clk) if (++cyc == 40000) begin nErrors++; final_report(); end
   always @(posedge sys_clk) altSrc <= rst ? 1'b0 : ~altSrc;
   initial begin
      rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 6'h00; avs_writedata = 32'h0; rtcCount = 16'h0;
      s = 32'h630B625C;
      for (int i = 0; i < NUM_INPUTS; i++) begin s = lfsr(s); levels[i*12+:12] = s[11:0]; end
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      bus(1'b0, REG_CTRL1, 32'h0);
      chk(q, 32'h1F);
      chk({sarOn, clkEn}, 32'h1);
      bus(1'b0, 6'h3C, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, REG_PINCTL, 32'hA5);
      chk(32'(pinOff), 32'hA5);
      for (int k = 0; k < 10; k++) conv(chs[k], 2'(k % 3), 2'(k % 4));
      $display("channel and format sweep done");
      bus(1'b1, REG_CTRL1, 32'h23);
      waitDone();
      bus(1'b0, REG_RES_LO, 32'h0);
      waitDone();
      chk(32'(q[C1_DONE_BIT]), 32'h1);
      bus(1'b1, REG_CTRL1, 32'h3F);
      repeat (60) @(posedge sys_clk);
      bus(1'b0, REG_CTRL1, 32'h0);
      chk({q[C1_DONE_BIT], 3'h0, sarOn}, 32'h0);
      $display("continuous and stop done");
      bus(1'b1, REG_CMP, 32'(levels[11:0]));
      bus(1'b1, REG_CTRL2, 32'h30);
      bus(1'b1, REG_CTRL1, 32'h00);
      waitDone();
      chk(32'(q[C1_DONE_BIT]), 32'h1);
      bus(1'b1, REG_CTRL2, 32'h20);
      bus(1'b1, REG_CTRL1, 32'h00);
      repeat (120) @(posedge sys_clk);
      bus(1'b0, REG_CTRL1, 32'h0);
      chk(32'(q[C1_DONE_BIT]), 32'h0);
      $display("compare done");
      bus(1'b1, REG_CTRL2, 32'h40);
      bus(1'b1, REG_CTRL1, 32'h05);
      rtcCount <= 16'h0055;
      waitDone();
      chk(32'(q[C1_DONE_BIT]), 32'h1);
      bus(1'b0, REG_RES_LO, 32'h0);
      repeat (60) @(posedge sys_clk);
      bus(1'b0, REG_CTRL1, 32'h0);
      chk(32'(q[C1_DONE_BIT]), 32'h0);
      $display("hardware trigger done");
      bus(1'b1, REG_CLKGATE, 32'h0);
      chk(32'(clkEn), 32'h0);
      repeat (4) @(posedge sys_clk);
      $display("clock gate done");
      final_report();
   end
endmodule : tb_top
